// ==== common/puip_consts.svh ====
/*
  Constants of the power-up initialisation and programming protection block:
  register offsets, reset values, timing counts and programming instruction codes.
  Assumes it is included by its bare name wherever the values are needed.
*/
`ifndef PUIP_CONSTS_SVH
`define PUIP_CONSTS_SVH

// Register offsets (byte addresses)
`define PUIP_OFF_PIN_OUT 8'h00
`define PUIP_OFF_PIN_OE 8'h04
`define PUIP_OFF_PIN_IN 8'h08
`define PUIP_OFF_STATUS 8'h0c

// Reset values
`define PUIP_RST_WORD 16'h0000
`define PUIP_RST_PINS 8'h00

// Timing: settle interval after the supply is good
`define PUIP_CLK_NS 50
`define PUIP_SETTLE_NS 1000
`define PUIP_SETTLE_CYC ((`PUIP_SETTLE_NS + `PUIP_CLK_NS - 1) / `PUIP_CLK_NS)

// Configuration memory layout
`define PUIP_CFG_WORDS 8
`define PUIP_WORD_OPT 3'h0
`define PUIP_WORD_OE 3'h1

// Pin positions of the programming port within the pin bus
`define PUIP_PIN_CLK 4
`define PUIP_PIN_MODE 5
`define PUIP_PIN_DIN 6
`define PUIP_PIN_DOUT 7

// Programming instruction codes
`define PUIP_IR_BYPASS 4'hf
`define PUIP_IR_ISP_EN 4'h1
`define PUIP_IR_ERASE 4'h2
`define PUIP_IR_PROG 4'h3
`define PUIP_IR_VERIFY 4'h4
`define PUIP_IR_SIG_RD 4'h5
`define PUIP_IR_SIG_WR 4'h6
`define PUIP_IR_SECURE 4'h7
`define PUIP_IR_ISP_DIS 4'h8
`define PUIP_IR_CAPTURE 4'h1

`endif

// ==== common/puip_pkg.sv ====
/*
  Types of the power-up initialisation and programming protection block.
  Assumes the constants header supplies all numeric values.
*/
package puip_pkg;

    // Programming port controller states
    typedef enum logic [3:0] {
        tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr, tap_pa_dr, tap_ex2_dr,
        tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir, tap_ex1_ir, tap_pa_ir, tap_ex2_ir, tap_upd_ir
    } puip_tap_state_t;

    // Option word held at configuration word 0
    typedef struct packed {
        logic [4:0] spare;
        logic hyst_large;
        logic port_off;
        logic keeper;
        logic [7:0] polarity;
    } puip_cfg_t;

endpackage

// ==== src/puip_top.sv ====
/*
  Power-up initialisation, reset hysteresis, security fuse, in-system programming
  over a four-pin test port, and pin protection during programming.
  Assumes: supply comparator levels and pins are asynchronous; APB master on core_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "puip_consts.svh"

module puip_top
    import puip_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Supply comparator levels
    input wire logic supply_above_hi_in,
    input wire logic supply_above_lo_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pins: 3..0 general, 7..4 programming port or general
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pin_keep_oe_out,
    output logic [7:0] pin_keep_level_out,
    // Status
    output logic init_done_out
);

    logic [15:0] cfg_mem [0:`PUIP_CFG_WORDS-1];
    logic [15:0] user_sig;
    logic secure;
    logic cfg_valid;
    logic isp_active;
    logic keep_sess;
    puip_cfg_t cfg;
    logic [7:0] pin_meta, pin_sync, pin_prev;
    logic hi_meta, hi_sync, lo_meta, lo_sync;
    logic supply_good;
    logic [7:0] settle_cnt;
    logic [7:0] user_out, user_oe;
    puip_tap_state_t tap;
    logic [3:0] ir, ir_sr;
    logic [18:0] dr_sr;
    logic bypass_bit;
    logic tdo, tdo_en;
    logic tck_rise, tck_fall, tms, tdi;
    logic port_on, init_pulse, isp_done;
    logic [3:0] next_ir;

    assign cfg = puip_cfg_t'(cfg_mem[`PUIP_WORD_OPT]);
    assign port_on = ~(cfg.port_off & cfg_valid);

    // Two-flop synchronisers for pins and comparators
    always_ff @(posedge core_clk_in) begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
        hi_meta <= supply_above_hi_in;
        hi_sync <= hi_meta;
        lo_meta <= supply_above_lo_in;
        lo_sync <= lo_meta;
    end

    // Port clock edges seen at core clock rate
    assign tck_rise = port_on & pin_sync[`PUIP_PIN_CLK] & ~pin_prev[`PUIP_PIN_CLK];
    assign tck_fall = port_on & ~pin_sync[`PUIP_PIN_CLK] & pin_prev[`PUIP_PIN_CLK];
    assign tms = pin_sync[`PUIP_PIN_MODE];
    assign tdi = pin_sync[`PUIP_PIN_DIN];
    assign next_ir = ir_sr;
    assign isp_done = tck_rise && tap == tap_upd_ir && next_ir == `PUIP_IR_ISP_DIS && isp_active;

    // Supply good with selectable hysteresis
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            supply_good <= 1'b0;
        end else if (cfg.hyst_large) begin
            // Large: rise at upper level, fall only below lower level
            if (hi_sync) begin
                supply_good <= 1'b1;
            end else if (!lo_sync) begin
                supply_good <= 1'b0;
            end
        end else begin
            supply_good <= hi_sync;
        end
    end

    // Settle delay, then one init pulse; reprogramming re-runs it
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !supply_good || isp_done) begin
            settle_cnt <= 8'h00;
            init_done_out <= 1'b0;
            init_pulse <= 1'b0;
        end else begin
            init_pulse <= 1'b0;
            if (!init_done_out) begin
                if (settle_cnt == 8'(`PUIP_SETTLE_CYC - 1)) begin
                    init_done_out <= 1'b1;
                    init_pulse <= 1'b1;
                end else begin
                    settle_cnt <= settle_cnt + 8'h01;
                end
            end
        end
    end

    // Port controller state; held in reset while the port is freed
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !port_on) begin
            tap <= tap_reset;
        end else if (tck_rise) begin
            case (tap)
                tap_reset: tap <= tms ? tap_reset : tap_idle;
                tap_idle: tap <= tms ? tap_sel_dr : tap_idle;
                tap_sel_dr: tap <= tms ? tap_sel_ir : tap_cap_dr;
                tap_cap_dr: tap <= tms ? tap_ex1_dr : tap_sh_dr;
                tap_sh_dr: tap <= tms ? tap_ex1_dr : tap_sh_dr;
                tap_ex1_dr: tap <= tms ? tap_upd_dr : tap_pa_dr;
                tap_pa_dr: tap <= tms ? tap_ex2_dr : tap_pa_dr;
                tap_ex2_dr: tap <= tms ? tap_upd_dr : tap_sh_dr;
                tap_upd_dr: tap <= tms ? tap_sel_dr : tap_idle;
                tap_sel_ir: tap <= tms ? tap_reset : tap_cap_ir;
                tap_cap_ir: tap <= tms ? tap_ex1_ir : tap_sh_ir;
                tap_sh_ir: tap <= tms ? tap_ex1_ir : tap_sh_ir;
                tap_ex1_ir: tap <= tms ? tap_upd_ir : tap_pa_ir;
                tap_pa_ir: tap <= tms ? tap_ex2_ir : tap_pa_ir;
                tap_ex2_ir: tap <= tms ? tap_upd_ir : tap_sh_ir;
                tap_upd_ir: tap <= tms ? tap_sel_dr : tap_idle;
                default: tap <= tap_reset;
            endcase
        end
    end

    // Instruction and data shift paths
    always_ff @(posedge core_clk_in) begin
        if (reset_in || tap == tap_reset) begin
            ir <= `PUIP_IR_BYPASS;
            ir_sr <= `PUIP_IR_CAPTURE;
            dr_sr <= 19'h00000;
            bypass_bit <= 1'b0;
        end else if (tck_rise) begin
            case (tap)
                tap_cap_ir: ir_sr <= `PUIP_IR_CAPTURE;
                tap_sh_ir: ir_sr <= {tdi, ir_sr[3:1]};
                tap_upd_ir: ir <= next_ir;
                tap_cap_dr: begin
                    bypass_bit <= 1'b0;
                    if (ir == `PUIP_IR_VERIFY) begin
                        // Secured part answers zeros instead of the pattern
                        dr_sr[15:0] <= secure ? 16'h0000 : cfg_mem[dr_sr[18:16]];
                    end else if (ir == `PUIP_IR_SIG_RD) begin
                        dr_sr <= {3'h0, user_sig};
                    end
                end
                tap_sh_dr: begin
                    bypass_bit <= tdi;
                    dr_sr <= {tdi, dr_sr[18:1]};
                end
                default: ;
            endcase
        end
    end

    // Serial output changes on the falling port clock
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !port_on) begin
            tdo <= 1'b0;
            tdo_en <= 1'b0;
        end else if (tck_fall) begin
            tdo_en <= (tap == tap_sh_ir) || (tap == tap_sh_dr);
            if (tap == tap_sh_ir) begin
                tdo <= ir_sr[0];
            end else if (ir == `PUIP_IR_BYPASS) begin
                tdo <= bypass_bit;
            end else begin
                tdo <= dr_sr[0];
            end
        end
    end

    // Session state; leaving without the closing instruction is an interruption
    always_ff @(posedge core_clk_in) begin
        if (reset_in || tap == tap_reset || !supply_good) begin
            isp_active <= 1'b0;
            keep_sess <= 1'b0;
        end else if (tck_rise && tap == tap_upd_ir) begin
            if (next_ir == `PUIP_IR_ISP_EN && !isp_active) begin
                isp_active <= 1'b1;
                keep_sess <= cfg.keeper & cfg_valid;
            end else if (next_ir == `PUIP_IR_ISP_DIS) begin
                isp_active <= 1'b0;
            end
        end
    end

    // Configuration store: erased at delivery, written only inside a session
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < `PUIP_CFG_WORDS; i++) begin
                cfg_mem[i] <= `PUIP_RST_WORD;
            end
            user_sig <= `PUIP_RST_WORD;
            secure <= 1'b0;
            cfg_valid <= 1'b0;
        end else if (tck_rise && isp_active) begin
            if (tap == tap_upd_ir && next_ir == `PUIP_IR_ERASE) begin
                for (int i = 0; i < `PUIP_CFG_WORDS; i++) begin
                    cfg_mem[i] <= `PUIP_RST_WORD;
                end
                user_sig <= `PUIP_RST_WORD;
                secure <= 1'b0;
                cfg_valid <= 1'b0;
            end else if (tap == tap_upd_ir && next_ir == `PUIP_IR_SECURE) begin
                secure <= 1'b1;
            end else if (tap == tap_upd_ir && next_ir == `PUIP_IR_ISP_DIS) begin
                cfg_valid <= 1'b1;
            end else if (tap == tap_upd_dr && ir == `PUIP_IR_PROG) begin
                cfg_mem[dr_sr[18:16]] <= dr_sr[15:0];
                cfg_valid <= 1'b0;
            end else if (tap == tap_upd_dr && ir == `PUIP_IR_SIG_WR) begin
                user_sig <= dr_sr[15:0];
            end
        end
    end

    // User output registers; init pulse loads polarity and enables
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            user_out <= `PUIP_RST_PINS;
            user_oe <= `PUIP_RST_PINS;
        end else if (init_pulse) begin
            user_out <= cfg.polarity;
            user_oe <= cfg_mem[`PUIP_WORD_OE][7:0];
        end else if (psel_in && penable_in && pwrite_in && pready_out) begin
            if (paddr_in == `PUIP_OFF_PIN_OUT) begin
                user_out <= pwdata_in[7:0];
            end else if (paddr_in == `PUIP_OFF_PIN_OE) begin
                user_oe <= pwdata_in[7:0];
            end
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
            if (psel_in && penable_in && !pready_out) begin
                case (paddr_in)
                    `PUIP_OFF_PIN_OUT: prdata_out <= {24'h000000, user_out};
                    `PUIP_OFF_PIN_OE: prdata_out <= {24'h000000, user_oe};
                    `PUIP_OFF_PIN_IN: prdata_out <= {24'h000000, pin_sync};
                    `PUIP_OFF_STATUS: prdata_out <= {25'h0, cfg.hyst_large, cfg.keeper, port_on,
                                                     secure, cfg_valid, isp_active, init_done_out};
                    default: pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    // Pin drivers: unconfigured, uninitialised or programming parts release every pin but the serial output
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !cfg_valid || !init_done_out || init_pulse || isp_active) begin
            pin_out <= `PUIP_RST_PINS;
            pin_oe_out <= `PUIP_RST_PINS;
        end else begin
            pin_out <= user_out;
            pin_oe_out <= user_oe;
        end
        // Serial output pin belongs to the port whenever it is enabled
        if (!reset_in && port_on) begin
            pin_out[7:4] <= {tdo, 3'h0};
            pin_oe_out[7:4] <= {tdo_en, 3'h0};
        end
    end

    // Keeper: weak hold of the last level seen on each pin
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_keep_oe_out <= `PUIP_RST_PINS;
            pin_keep_level_out <= `PUIP_RST_PINS;
        end else begin
            pin_keep_level_out <= pin_sync;
            if (isp_active) begin
                pin_keep_oe_out <= {8{keep_sess}};
            end else begin
                pin_keep_oe_out <= {8{cfg.keeper & cfg_valid}};
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/puip_monitor.sv ====
/*
  Checker on the top ports: APB answer timing, power-up init and pin release.
  Assumes it is bound into puip_top by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module puip_monitor (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Supply levels
    input wire logic supply_above_hi_in,
    input wire logic supply_above_lo_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Pins and status
    input wire logic [7:0] pin_oe_out,
    input wire logic init_done_out
);
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    // APB: one wait state, single-cycle answer, error only for holes in the map
    property p_apb_wait; psel_in && penable_in && !pready_out |=> pready_out; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("APB answer not after one wait state");
    property p_rdy_pulse; pready_out |=> !pready_out; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_upper_zero; prdata_out[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
    property p_err_zero; pslverr_out |-> pready_out && prdata_out == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
    property p_err_cause; pready_out |-> pslverr_out == (paddr_in > 8'h0c || paddr_in[1:0] != 2'h0); endproperty
    a_err_cause: assert property (p_err_cause) else $error("error flag does not match address");
    // Init needs a settled supply; losing it ends init; pins stay off meanwhile
    property p_init_delay; $rose(init_done_out) |-> $past(supply_above_hi_in, 20); endproperty
    a_init_delay: assert property (p_init_delay) else $error("init done too early");
    property p_supply_loss; !supply_above_lo_in |-> ##[1:5] !init_done_out; endproperty
    a_supply_loss: assert property (p_supply_loss) else $error("init kept after supply loss");
    property p_oe_off; !init_done_out [*2] |-> pin_oe_out[3:0] == 4'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven without init");
endmodule
`default_nettype wire

// ==== test/puip_prog_model.sv ====
/*
  Programming-port master: drives port clock, mode and data in, reads serial out.
  Assumes the bench calls one task at a time and routes its pins.
*/
`timescale 1ns/1ps
`default_nettype none
module puip_prog_model (
    // Core clock paces the port clock
    input wire logic clk_in,
    // Port pins
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // Port clock idles low, so no edge lands in the settle interval
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One port clock, half-periods well above the sync delay
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk_in);
        tms_out <= m;
        tdi_out <= d;
        repeat (5) @(posedge clk_in);
        q = tdo_in;
        tck_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        tck_out <= 1'b0;
    endtask
    // Idle to capture, shift LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [18:0] din, output logic [18:0] dout);
        logic q;
        dout = 19'h0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    // Five mode-high clocks reset the port; also how a session is cut short
    task automatic reset_port();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// ==== test/test_powerup_init_and_isp_protection.sv ====
/*
  Bench: APB access, power-up init, hysteresis, programming sessions, security.
  Assumes the constants header and the programming-port model on pins 4..7.
*/
`timescale 1ns/1ps
`default_nettype none
`include "puip_consts.svh"
module test_powerup_init_and_isp_protection;
    // Bench state, driven stimulus defined at time zero
    logic core_clk_in = 1'b0, reset_in = 1'b1, hi = 1'b0, lo = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, flt = 8'h00, pin_out, pin_oe, keep_oe, keep_lvl;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, init_done, tck, tms, tdi, e;
    logic [18:0] so;
    wire logic [7:0] pin_w;
    int err_total = 0, n_checks = 0;
    // Clock
    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    // Drivers beat keepers; an undriven line wanders so no value passes by luck
    always @(posedge core_clk_in) flt <= ~flt;
    assign pin_w = (pin_oe & pin_out) | (~pin_oe & keep_oe & keep_lvl) | (~pin_oe & ~keep_oe & flt);
    puip_top puip_top_inst (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .supply_above_hi_in(hi), .supply_above_lo_in(lo),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_in({pin_w[7], tdi, tms, tck, pin_w[3:0]}), .pin_out(pin_out), .pin_oe_out(pin_oe),
        .pin_keep_oe_out(keep_oe), .pin_keep_level_out(keep_lvl), .init_done_out(init_done)
    );
    puip_prog_model puip_prog_model_inst (.clk_in(core_clk_in), .tdo_in(pin_w[7]), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A wait that runs out ends the run
    task automatic hang(input int n);
        if (n >= 400) begin
            err_total++;
            stop_test();
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        for (int n = 0; n <= 400; n++) begin
            @(posedge core_clk_in);
            if (pready === 1'b1) break;
            hang(n);
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait for init low, init high, or user pins driven
    task automatic wt(input int k);
        for (int n = 0; n <= 400; n++) begin
            @(posedge core_clk_in);
            if (k == 0 ? init_done === 1'b0 : k == 1 ? init_done === 1'b1 : pin_oe[3:0] === 4'hf) break;
            hang(n);
        end
    endtask
    task automatic ir(input logic [3:0] c);
        puip_prog_model_inst.scan(1'b1, 4, {15'h0, c}, so);
    endtask
    task automatic dr(input logic [18:0] v);
        puip_prog_model_inst.scan(1'b0, 19, v, so);
    endtask
    initial begin
        repeat (16) @(posedge core_clk_in);
        reset_in <= 1'b0;
        // Fresh part: erased, port on, pins released; hole in the map refused
        apb(1'b0, `PUIP_OFF_STATUS, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], e}, 32'h1);
        hi <= 1'b1;
        lo <= 1'b1;
        wt(1);
        chk({24'h0, pin_oe}, 32'h0);
        apb(1'b1, `PUIP_OFF_PIN_OUT, 32'h5a);
        apb(1'b1, `PUIP_OFF_STATUS, 32'hff);
        apb(1'b0, `PUIP_OFF_PIN_OUT, 32'h0);
        chk(rd, 32'h5a);
        apb(1'b0, `PUIP_OFF_STATUS, 32'h0);
        chk(rd, 32'h11);
        $display("test 1 done");
        // Session writes keeper, large hysteresis, polarity, OE and signature
        puip_prog_model_inst.reset_port();
        ir(`PUIP_IR_ISP_EN);
        chk({13'h0, so}, 32'h1);
        chk({24'h0, keep_oe}, 32'h0);
        ir(`PUIP_IR_ERASE);
        ir(`PUIP_IR_PROG);
        dr({3'h0, 16'h050f});
        dr({3'h1, 16'h000f});
        ir(`PUIP_IR_SIG_WR);
        dr({3'h0, 16'hbeef});
        ir(`PUIP_IR_ISP_DIS);
        wt(2);
        chk({24'h0, pin_out & 8'h0f}, 32'hf);
        apb(1'b0, `PUIP_OFF_STATUS, 32'h0);
        chk(rd, 32'h75);
        // Large hysteresis rides a dip below the upper level only
        hi <= 1'b0;
        repeat (12) @(posedge core_clk_in);
        chk({31'h0, init_done}, 32'h1);
        lo <= 1'b0;
        wt(0);
        repeat (2) @(posedge core_clk_in);
        chk({24'h0, pin_oe}, 32'h0);
        hi <= 1'b1;
        lo <= 1'b1;
        wt(2);
        $display("test 2 done");
        // Keepers hold prior levels; security hides the pattern, not the signature
        ir(`PUIP_IR_ISP_EN);
        repeat (8) @(posedge core_clk_in);
        chk({20'h0, pin_oe[3:0], keep_oe[3:0], keep_lvl[3:0]}, 32'h0ff);
        for (int s = 0; s < 2; s++) begin
            if (s == 1) ir(`PUIP_IR_SECURE);
            ir(`PUIP_IR_VERIFY);
            dr(19'h0);
            dr(19'h0);
            chk({16'h0, so[15:0]}, s == 0 ? 32'h050f : 32'h0);
        end
        ir(`PUIP_IR_SIG_RD);
        dr(19'h0);
        chk({13'h0, so}, 32'hbeef);
        ir(`PUIP_IR_ISP_DIS);
        wt(2);
        $display("test 3 done");
        // Session cut short after erase: pins stay released
        ir(`PUIP_IR_ISP_EN);
        ir(`PUIP_IR_ERASE);
        puip_prog_model_inst.reset_port();
        repeat (40) @(posedge core_clk_in);
        chk({24'h0, pin_oe}, 32'h0);
        apb(1'b0, `PUIP_OFF_STATUS, 32'h0);
        chk(rd & 32'h6, 32'h0);
        $display("test 4 done");
        // Freed port applies once the session closes; small hysteresis drops on the upper level
        ir(`PUIP_IR_ISP_EN);
        ir(`PUIP_IR_PROG);
        dr({3'h0, 16'h02a5});
        dr({3'h1, 16'h00ff});
        ir(`PUIP_IR_ISP_DIS);
        wt(2);
        chk({16'h0, pin_oe, pin_out}, 32'hffa5);
        apb(1'b0, `PUIP_OFF_STATUS, 32'h0);
        chk(rd, 32'h05);
        hi <= 1'b0;
        wt(0);
        chk({31'h0, init_done}, 32'h0);
        $display("test 5 done");
        stop_test();
    end
endmodule
bind puip_top puip_monitor puip_monitor_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .supply_above_hi_in(supply_above_hi_in), .supply_above_lo_in(supply_above_lo_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pin_oe_out(pin_oe_out), .init_done_out(init_done_out));
`default_nettype wire
